// file: design/seq_fifo_ref_common_mode_select_config.sv
// Register access over APB and the address map were decided locally.
module seq_fifo_ref_common_mode_select_config
    import seqref_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [seqref_pkg::ADDR_W-1:0] PADDR,
    input wire logic [seqref_pkg::DATA_W-1:0] PWDATA,
    output logic [seqref_pkg::DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic CONVERT_START,
    output logic [seqref_pkg::CH_W-1:0] MUX_PAIR,
    output logic NEG_A_INTERNAL,
    output logic NEG_B_INTERNAL,
    output logic REF_A_OUTPUT_TWO,
    output logic REF_B_OUTPUT_TWO,
    output logic [seqref_pkg::CH_W-1:0] FIFO_DEPTH,
    output logic [seqref_pkg::FILL_W-1:0] FIFO_FILL,
    output logic FIFO_DISCARD
);
    import seqref_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [REG_W-1:0] seq_cfg;
        logic [REG_W-1:0] ref_cm;
        logic [CTRL_W-1:0] ctrl;
        logic [CH_W-1:0] position;
        logic [CH_W-1:0] channel;
        logic [CH_W-1:0] depth;
        logic [FILL_W-1:0] fill;
        logic discard;
        logic neg_a;
        logic neg_b;
        logic ref_a;
        logic ref_b;
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } cfg_state_t;

    cfg_state_t state_r;
    cfg_state_t state_nxt;
    apb_req_t req;
    route_in_t route_a;
    route_in_t route_b;
    logic conv_rise;
    logic neg_a_w;
    logic neg_b_w;
    logic ref_a_w;
    logic ref_b_w;
    logic seq_active;
    logic fifo_on;
    logic [CH_W-1:0] seq_len;
    logic [FILL_W-1:0] fill_full;
    logic wr_hit;
    logic rd_setup;

    // ------------------------------------------------------------
    // Bus bundle
    // ------------------------------------------------------------
    assign req.psel = PSEL;
    assign req.penable = PENABLE;
    assign req.pwrite = PWRITE;
    assign req.paddr = PADDR;
    assign req.pwdata = PWDATA;

    // ------------------------------------------------------------
    // Conversion start edge
    // ------------------------------------------------------------
    rise_detect u_conv_edge (
        .clk(CLK_SYS),
        .rst(RST),
        .level(CONVERT_START),
        .rise(conv_rise)
    );

    // ------------------------------------------------------------
    // Negative input and reference routing per converter
    // ------------------------------------------------------------
    // Fed from registered state so no loop through the next value
    assign route_a.common_src = state_r.ref_cm[COMMON_A_LSB +: SIDE_W];
    assign route_a.ref_sel = state_r.ref_cm[REFA_LSB +: SIDE_W];
    assign route_a.channel = state_r.channel;
    assign route_a.pseudo_diff = state_r.ctrl[CTRL_PSEUDO];
    assign route_b.common_src = state_r.ref_cm[COMMON_B_LSB +: SIDE_W];
    assign route_b.ref_sel = state_r.ref_cm[REFB_LSB +: SIDE_W];
    assign route_b.channel = state_r.channel;
    assign route_b.pseudo_diff = state_r.ctrl[CTRL_PSEUDO];

    side_route u_route_a (
        .cfg(route_a),
        .neg_internal(neg_a_w),
        .ref_two(ref_a_w)
    );

    side_route u_route_b (
        .cfg(route_b),
        .neg_internal(neg_b_w),
        .ref_two(ref_b_w)
    );

    // ------------------------------------------------------------
    // Mode decode from registered configuration
    // ------------------------------------------------------------
    assign seq_len = state_r.ctrl[CTRL_LEN_LSB +: CH_W];
    assign seq_active = state_r.ctrl[CTRL_AUTO]
        & state_r.ctrl[CTRL_PSEUDO]
        & (seq_len != LEN_OFF);
    assign fifo_on = state_r.ctrl[CTRL_FIFO_EN];
    // Full when fill reaches depth code plus one
    assign fill_full = {1'b0, state_r.depth} + FILL_STEP;
    assign wr_hit = req.psel & req.penable & state_r.pready & req.pwrite;
    assign rd_setup = req.psel & ~req.penable;

    // Channel of a slot position
    function automatic logic [CH_W-1:0] slot_channel(
        input logic [REG_W-1:0] cfg,
        input logic [CH_W-1:0] pos
    );
        logic [CH_W-1:0] ch;
        ch = cfg[SLOT1_LSB +: CH_W];
        case (pos)
            2'h1: ch = cfg[SLOT2_LSB +: CH_W];
            2'h2: ch = cfg[SLOT3_LSB +: CH_W];
            2'h3: ch = cfg[SLOT4_LSB +: CH_W];
            default: ch = cfg[SLOT1_LSB +: CH_W];
        endcase
        return ch;
    endfunction

    // Read view of one register
    function automatic logic [DATA_W-1:0] read_view(
        input cfg_state_t s,
        input logic [ADDR_W-1:0] addr
    );
        logic [DATA_W-1:0] v;
        v = '0;
        if (addr == OFS_SEQ_CFG) begin
            v[REG_W-1:0] = s.seq_cfg;
            v[POS_LSB +: CH_W] = s.position;
        end else if (addr == OFS_REF_CM) begin
            v[REG_W-1:0] = s.ref_cm;
        end else if (addr == OFS_CTRL) begin
            v[CTRL_W-1:0] = s.ctrl;
        end else if (addr == OFS_STATUS) begin
            v[FILL_W-1:0] = s.fill;
        end
        return v;
    endfunction

    // Address in map
    function automatic logic mapped(input logic [ADDR_W-1:0] addr);
        logic hit;
        hit = 1'b0;
        if (addr == OFS_SEQ_CFG) begin
            hit = 1'b1;
        end else if (addr == OFS_REF_CM) begin
            hit = 1'b1;
        end else if (addr == OFS_CTRL) begin
            hit = 1'b1;
        end else if (addr == OFS_STATUS) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        state_nxt.discard = 1'b0;

        // APB: answer in the first access cycle, no wait states
        state_nxt.pready = 1'b0;
        state_nxt.pslverr = 1'b0;
        if (rd_setup) begin
            state_nxt.pready = 1'b1;
            state_nxt.pslverr = ~mapped(req.paddr);
            state_nxt.prdata = req.pwrite ? '0
                : read_view(state_r, req.paddr);
        end else if (req.psel & req.penable & state_r.pready) begin
            state_nxt.prdata = '0;
        end

        // Register writes; status register and bad offsets ignore them
        if (wr_hit) begin
            if (req.paddr == OFS_SEQ_CFG) begin
                // Position bits masked out of the stored copy
                state_nxt.seq_cfg = req.pwdata[REG_W-1:0]
                    & SEQ_WR_MASK;
            end else if (req.paddr == OFS_REF_CM) begin
                // Order against the sequencer write is the host's duty
                state_nxt.ref_cm = req.pwdata[REG_W-1:0];
            end else if (req.paddr == OFS_CTRL) begin
                state_nxt.ctrl = req.pwdata[CTRL_W-1:0];
            end
        end

        // Sequencer position: steps on each start, else parks on slot one
        if (!seq_active) begin
            state_nxt.position = POS_FIRST;
        end else if (conv_rise) begin
            if (state_r.position >= seq_len) begin
                state_nxt.position = POS_FIRST;
            end else begin
                state_nxt.position = state_r.position + POS_STEP;
            end
        end

        // Input pair for the next conversion
        if (seq_active) begin
            state_nxt.channel = slot_channel(state_r.seq_cfg,
                state_nxt.position);
        end else begin
            state_nxt.channel = state_r.seq_cfg[SLOT1_LSB +: CH_W];
        end

        // FIFO depth applies only while enabled
        if (fifo_on) begin
            state_nxt.depth = state_r.seq_cfg[DEPTH_LSB +: CH_W];
        end else begin
            state_nxt.depth = '0;
        end

        // Fill count; a full FIFO drops its oldest entry instead
        if (!fifo_on) begin
            state_nxt.fill = '0;
        end else if (state_r.fill > fill_full) begin
            // Depth lowered under a fuller FIFO
            state_nxt.fill = fill_full;
        end else if (conv_rise) begin
            if (state_r.fill == fill_full) begin
                state_nxt.discard = 1'b1;
            end else begin
                state_nxt.fill = state_r.fill + FILL_STEP;
            end
        end

        // Routing outputs, one cycle behind configuration
        state_nxt.neg_a = neg_a_w;
        state_nxt.neg_b = neg_b_w;
        state_nxt.ref_a = ref_a_w;
        state_nxt.ref_b = ref_b_w;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_r <= '0;
            state_r.seq_cfg <= SEQ_CFG_RST;
            state_r.ref_cm <= REF_CM_RST;
            state_r.ctrl <= CTRL_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs straight from flip-flops
    // ------------------------------------------------------------
    assign PRDATA = state_r.prdata;
    assign PREADY = state_r.pready;
    assign PSLVERR = state_r.pslverr;
    assign MUX_PAIR = state_r.channel;
    assign NEG_A_INTERNAL = state_r.neg_a;
    assign NEG_B_INTERNAL = state_r.neg_b;
    assign REF_A_OUTPUT_TWO = state_r.ref_a;
    assign REF_B_OUTPUT_TWO = state_r.ref_b;
    assign FIFO_DEPTH = state_r.depth;
    assign FIFO_FILL = state_r.fill;
    assign FIFO_DISCARD = state_r.discard;
endmodule // seq_fifo_ref_common_mode_select_config

// file: design/seqref_pkg.sv
package seqref_pkg;

    // ------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam logic [ADDR_W-1:0] OFS_SEQ_CFG = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_REF_CM = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;

    // ------------------------------------------------------------
    // Reset values and sequencer write mask
    // ------------------------------------------------------------
    localparam logic [REG_W-1:0] SEQ_CFG_RST = 16'h0000;
    localparam logic [REG_W-1:0] REF_CM_RST = 16'h0000;
    localparam logic [REG_W-1:0] SEQ_WR_MASK = 16'hfff3;

    // ------------------------------------------------------------
    // Sequencer and FIFO configuration fields
    // ------------------------------------------------------------
    localparam int CH_W = 2;
    localparam int SLOT1_LSB = 10;
    localparam int SLOT2_LSB = 8;
    localparam int SLOT3_LSB = 6;
    localparam int SLOT4_LSB = 4;
    localparam int POS_LSB = 2;
    localparam int DEPTH_LSB = 0;

    // ------------------------------------------------------------
    // Reference and common-mode fields
    // ------------------------------------------------------------
    localparam int SIDE_W = 4;
    localparam int COMMON_B_LSB = 12;
    localparam int COMMON_A_LSB = 8;
    localparam int REFB_LSB = 4;
    localparam int REFA_LSB = 0;
    localparam int DIFF_PAIR0_BIT = 0;
    localparam int DIFF_PAIR1_BIT = 3;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_W = 5;
    localparam int CTRL_FIFO_EN = 0;
    localparam int CTRL_LEN_LSB = 1;
    localparam int CTRL_PSEUDO = 3;
    localparam int CTRL_AUTO = 4;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

    // ------------------------------------------------------------
    // Counts
    // ------------------------------------------------------------
    localparam int FILL_W = 3;
    localparam logic [CH_W-1:0] POS_FIRST = 2'h0;
    localparam logic [CH_W-1:0] POS_STEP = 2'h1;
    localparam logic [CH_W-1:0] LEN_OFF = 2'h0;
    localparam logic [FILL_W-1:0] FILL_STEP = 3'h1;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [SIDE_W-1:0] common_src;
        logic [SIDE_W-1:0] ref_sel;
        logic [CH_W-1:0] channel;
        logic pseudo_diff;
    } route_in_t;

    typedef struct packed {
        logic prev;
    } edge_state_t;

endpackage

// file: design/rise_detect.sv
module rise_detect
    import seqref_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic level,
    output logic rise
);
    edge_state_t state_r;
    edge_state_t state_nxt;

    // Remember last level
    always_comb begin
        state_nxt = state_r;
        state_nxt.prev = level;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // A level held high gives one pulse only
    assign rise = level & ~state_r.prev;
endmodule // rise_detect

// file: design/side_route.sv
module side_route
    import seqref_pkg::*;
(
    input route_in_t cfg,
    output logic neg_internal,
    output logic ref_two
);
    logic [1:0] pick;

    // Choose which channel bit governs the selected input
    always_comb begin
        pick = cfg.channel;
        neg_internal = 1'b0;
        ref_two = 1'b0;
        if (cfg.pseudo_diff) begin
            neg_internal = cfg.common_src[pick];
            ref_two = cfg.ref_sel[pick];
        end else begin
            // Fully differential: only pairs 0 and 1 exist
            if (cfg.channel[0]) begin
                ref_two = cfg.ref_sel[DIFF_PAIR1_BIT];
            end else begin
                ref_two = cfg.ref_sel[DIFF_PAIR0_BIT];
            end
        end
    end
endmodule // side_route

// file: verification/seqref_chk.sv
// ------------------------------------------------------------
// Port-level checks on the configuration block
// ------------------------------------------------------------
module seqref_chk (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic CONVERT_START,
    input wire logic [1:0] MUX_PAIR,
    input wire logic NEG_A_INTERNAL,
    input wire logic NEG_B_INTERNAL,
    input wire logic REF_A_OUTPUT_TWO,
    input wire logic REF_B_OUTPUT_TWO,
    input wire logic [1:0] FIFO_DEPTH,
    input wire logic [2:0] FIFO_FILL,
    input wire logic FIFO_DISCARD
);
    logic wr_done;
    logic [3:0] rt;
    logic rst_q;
    // Outputs jump mid-cycle at reset; checks rest one edge after release
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rst_q <= 1'b1;
        end else begin
            rst_q <= 1'b0;
        end
    end
    // A completed write is the only cause of change besides a start
    assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
    assign rt = {NEG_A_INTERNAL, NEG_B_INTERNAL, REF_A_OUTPUT_TWO,
        REF_B_OUTPUT_TWO};
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST || rst_q);
    a_ready_answer:
        assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no answer after setup");
    a_ready_single:
        assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    a_err_with_ready:
        assert property (PSLVERR |-> PREADY)
        else $error("error outside access");
    a_rdata_idle:
        assert property (!(PREADY && !PWRITE) |-> PRDATA == 32'h0)
        else $error("read data outside read");
    a_fill_range:
        assert property (FIFO_FILL <= {1'b0, FIFO_DEPTH} + 3'h1)
        else $error("fill beyond depth");
    a_fill_step:
        assert property (FIFO_FILL > $past(FIFO_FILL) |->
            FIFO_FILL == $past(FIFO_FILL) + 3'h1 &&
            $past(CONVERT_START) && !$past(CONVERT_START, 2))
        else $error("fill grew without start");
    a_discard_full:
        assert property (FIFO_DISCARD |->
            FIFO_FILL == {1'b0, FIFO_DEPTH} + 3'h1 && $stable(FIFO_FILL)
            && $past(CONVERT_START) && !$past(CONVERT_START, 2))
        else $error("discard while not full");
    a_mux_cause:
        assert property (!$stable(MUX_PAIR) |->
            ($past(CONVERT_START) && !$past(CONVERT_START, 2)) ||
            $past(wr_done, 2))
        else $error("pair moved without cause");
    // Reference register or mode write shows two edges on, slot write three
    a_route_cause:
        assert property (!$stable(rt) |->
            ($past(CONVERT_START, 2) && !$past(CONVERT_START, 3)) ||
            $past(wr_done, 2) || $past(wr_done, 3))
        else $error("routing moved without cause");
endmodule // seqref_chk

bind seq_fifo_ref_common_mode_select_config seqref_chk i_seqref_chk (
    .CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .CONVERT_START(CONVERT_START),
    .MUX_PAIR(MUX_PAIR), .NEG_A_INTERNAL(NEG_A_INTERNAL),
    .NEG_B_INTERNAL(NEG_B_INTERNAL), .REF_A_OUTPUT_TWO(REF_A_OUTPUT_TWO),
    .REF_B_OUTPUT_TWO(REF_B_OUTPUT_TWO), .FIFO_DEPTH(FIFO_DEPTH),
    .FIFO_FILL(FIFO_FILL), .FIFO_DISCARD(FIFO_DISCARD)
);

// file: verification/apb_host.sv
// ------------------------------------------------------------
// Host controller model on the register bus
// ------------------------------------------------------------
module apb_host (
    input wire logic clk,
    input wire logic pready,
    input wire logic [seqref_pkg::DATA_W-1:0] prdata,
    input wire logic pslverr,
    output seqref_pkg::apb_req_t req
);
    import seqref_pkg::*;
    initial req = '0;
    // Call just after an edge; request held until ready is sampled
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] rd,
            output logic err);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        // Released lines change so a stale value is never mistaken
        req <= '{1'b0, 1'b0, wr, ~a, ~d};
    endtask
endmodule // apb_host

// file: verification/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import seqref_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and checking
    // ------------------------------------------------------------
    logic CLK_SYS, RST, CONVERT_START, PREADY, PSLVERR, err, FIFO_DISCARD;
    logic NEG_A_INTERNAL, NEG_B_INTERNAL, REF_A_OUTPUT_TWO, REF_B_OUTPUT_TWO;
    logic [1:0] MUX_PAIR, FIFO_DEPTH;
    logic [2:0] FIFO_FILL;
    logic [3:0] rt;
    logic [31:0] PRDATA, rd;
    apb_req_t req;
    int errors, check_count, cyc;
    assign rt = {NEG_A_INTERNAL, NEG_B_INTERNAL, REF_A_OUTPUT_TWO,
        REF_B_OUTPUT_TWO};

    seq_fifo_ref_common_mode_select_config i_seq_fifo_ref_common_mode_select_config (
        .CLK_SYS, .RST, .PSEL(req.psel), .PENABLE(req.penable),
        .PWRITE(req.pwrite), .PADDR(req.paddr), .PWDATA(req.pwdata),
        .PRDATA, .PREADY, .PSLVERR, .CONVERT_START, .MUX_PAIR,
        .NEG_A_INTERNAL, .NEG_B_INTERNAL, .REF_A_OUTPUT_TWO,
        .REF_B_OUTPUT_TWO, .FIFO_DEPTH, .FIFO_FILL, .FIFO_DISCARD);
    apb_host i_apb_host (.clk(CLK_SYS), .pready(PREADY), .prdata(PRDATA),
        .pslverr(PSLVERR), .req(req));

    initial begin
        CLK_SYS = 1'b0;
        forever #12.5 CLK_SYS = ~CLK_SYS;
    end
    // Ceiling far above the few hundred cycles the run needs
    always @(posedge CLK_SYS) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // A clock edge passes after each transfer before the next request
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_apb_host.xfer(1'b1, a, {16'h0000, d}, rd, err);
        @(posedge CLK_SYS);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
            input logic ee);
        i_apb_host.xfer(1'b0, a, 32'h0, rd, err);
        chk(rd, e);
        chk({31'h0, err}, {31'h0, ee});
        @(posedge CLK_SYS);
    endtask
    // One start pulse; discard pulses counted over the next edges
    task automatic conv(output int n);
        n = 0;
        CONVERT_START <= 1'b1;
        repeat (5) begin
            @(posedge CLK_SYS);
            CONVERT_START <= 1'b0;
            n += int'(FIFO_DISCARD === 1'b1);
        end
    endtask
    task automatic reset_check();
        rdchk(OFS_SEQ_CFG, 32'h0, 1'b0);
        rdchk(OFS_REF_CM, 32'h0, 1'b0);
        chk({26'h0, MUX_PAIR, rt}, 32'h0);
        rdchk(8'h10, 32'h0, 1'b1);
        wr(OFS_STATUS, 16'h0007);
        rdchk(OFS_STATUS, 32'h0, 1'b0);
        wr(OFS_SEQ_CFG, 16'hffff);
        rdchk(OFS_SEQ_CFG, 32'hfff3, 1'b0);
        chk({30'h0, FIFO_DEPTH}, 32'h0);
    endtask
    task automatic route_check(input logic [15:0] v);
        logic [3:0] e;
        for (int m = 0; m < 2; m++) begin
            wr(OFS_CTRL, m ? 16'h0008 : 16'h0000);
            for (int p = 0; p < 4; p++) begin
                wr(OFS_SEQ_CFG, 16'(p << 10));
                wr(OFS_REF_CM, v);
                repeat (3) @(posedge CLK_SYS);
                if (m)
                    e = {v[8+p], v[12+p], v[p], v[4+p]};
                else
                    e = {2'b00, v[p%2 ? 3 : 0], v[p%2 ? 7 : 4]};
                chk({28'h0, rt}, {28'h0, e});
                chk({30'h0, MUX_PAIR}, 32'(p));
            end
        end
        rdchk(OFS_REF_CM, {16'h0, v}, 1'b0);
    endtask
    task automatic seq_run(input logic [15:0] c, input int s);
        int n;
        logic [1:0] pos;
        wr(OFS_CTRL, 16'h0000);
        wr(OFS_SEQ_CFG, 16'h0b1d);
        wr(OFS_CTRL, c);
        for (int k = 1; k < 6; k++) begin
            conv(n);
            pos = 2'(k % s);
            rdchk(OFS_SEQ_CFG, {16'h0000, 12'h0b1, pos, 2'b01},
                1'b0);
            chk({30'h0, MUX_PAIR}, {30'h0, pos + 2'h2});
            chk({29'h0, FIFO_FILL}, 32'(k < 2 ? k : 2));
            chk(32'(n), 32'(k > 2));
        end
        chk({30'h0, FIFO_DEPTH}, 32'h1);
    endtask
    task automatic finish_test();
        $display("Checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        RST = 1'b1;
        CONVERT_START = 1'b0;
        repeat (3) @(posedge CLK_SYS);
        RST <= 1'b0;
        @(posedge CLK_SYS);
        reset_check();
        route_check(16'h36c9);
        route_check(16'hc936);
        seq_run(16'h001f, 4);
        seq_run(16'h001b, 2);
        seq_run(16'h001d, 3);
        seq_run(16'h0019, 1);
        seq_run(16'h0017, 1);
        wr(OFS_REF_CM, 16'hffff);
        RST <= 1'b1;
        @(posedge CLK_SYS);
        RST <= 1'b0;
        @(posedge CLK_SYS);
        rdchk(OFS_REF_CM, 32'h0, 1'b0);
        finish_test();
    end
endmodule // testbench
